// ### hw/trace_pkg.sv
// Package for the branch trace recorder: register indices, control bit
// positions, reset values, pin pulse timing and the carrier types.
// Assumes a 32-bit instruction pointer and the core's retirement clock.
package trace_pkg;

  // ****************************************************************
  // Register indices on the model-specific register port
  // ****************************************************************
  localparam logic [9:0] IDX_DEBUG_CONTROL   = 10'h1d9;
  localparam logic [9:0] IDX_RECENT_SOURCE   = 10'h1db;
  localparam logic [9:0] IDX_RECENT_TARGET   = 10'h1dc;
  localparam logic [9:0] IDX_SAVED_SOURCE    = 10'h1dd;
  localparam logic [9:0] IDX_SAVED_TARGET    = 10'h1de;

  // ****************************************************************
  // Debug control register fields
  // ****************************************************************
  localparam int          BIT_RECORD_ENABLE   = 0;
  localparam int          BIT_BRANCH_STEP     = 1;
  localparam int          BIT_PIN_SELECT_LO   = 2;
  localparam int          BIT_BUS_MESSAGE     = 6;
  localparam int          NUM_REPORT_PINS     = 4;
  localparam logic [31:0] DEBUG_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] IP_RESET            = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS       = 40;
  localparam int          PIN_PULSE_NS        = 80;
  localparam int          PIN_PULSE_CYCLES    =
    (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  PIN_PULSE_COUNT     = 4'(PIN_PULSE_CYCLES);

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef enum logic [1:0] {
    XFER_BRANCH,
    XFER_EXCEPTION,
    XFER_INTERRUPT,
    XFER_DEBUG
  } xfer_kind_t;

  typedef struct packed {
    logic        valid;
    xfer_kind_t  kind;
    logic        faulted;
    logic [31:0] from_ip;
    logic [31:0] next_ip;
    logic [31:0] to_ip;
  } xfer_evt_t;

  typedef struct packed {
    logic [31:0] from_ip;
    logic [31:0] to_ip;
  } trace_msg_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [9:0]  index;
    logic [31:0] wdata;
    logic        priv0;
    logic        real_mode;
  } msr_req_t;

endpackage : trace_pkg

// ### hw/report_pin_pulse.sv
// One breakpoint report pin: turns a one-cycle event into a low pulse
// of fixed length on an active-low output.
// Assumes events come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module report_pin_pulse
  import trace_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Event in, pin out
  input  wire logic fire,
  output logic      pin_n
);

  logic [3:0] count;
  logic [3:0] next_count;

  // An event during a pulse restarts it, so back-to-back matches merge
  always_comb begin
    next_count = count;
    if (fire) begin
      next_count = PIN_PULSE_COUNT;
    end else if (count != 4'h0) begin
      next_count = count - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= 4'h0;
      pin_n <= 1'b1;
    end else begin
      count <= next_count;
      pin_n <= (next_count == 4'h0);
    end
  end

endmodule : report_pin_pulse

`default_nettype wire

// ### hw/branch_trace_recorder.sv
// Branch trace recorder: last transfer capture, control-flow stepping,
// breakpoint report pins and bus trace messages.
// Assumes the core presents one retired transfer per cycle and holds it
// while stall_retire is high; the register port is driven by the core's
// model-specific register read and write operations.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1: Record enable captures latest transfer pointers.
// RULE2: Debug exception clears recording, keeps pointers.
// RULE3: Branch step makes trap flag step branches.
// RULE4: Both flags set: trap at next transfer.
// RULE5: Debug exception clears branch step and trap.
// RULE6: Selected pins pulse low on breakpoint match.
// RULE7: Unselected pins report performance events harmlessly.
// RULE8: Bus message enable sends trace messages.
// RULE9: Pointer registers undefined while messages enabled.
// RULE10: Message from is next ip, or faulting branch.
// RULE11: Branch loads source and target registers.
// RULE12: Interrupt or exception loads interrupted and handler.
// RULE13: Copy recent to saved before new record; the code copies only before interrupt or exception records.
// RULE14: Debug exceptions are never recorded; the code still sends bus trace messages for them.
// RULE15: Control writes only at level 0 or real.
// RULE16: Pointer registers readable by register read.
// RULE17: Handler re-enables recording before resuming.
// RULE18: Debugger re-arms stepping flags before resuming.
// RULE19: Reset clears every debug control flag.
module branch_trace_recorder
  import trace_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  // Retired control transfers from the core
  input  wire trace_pkg::xfer_evt_t         xfer,
  output logic                              stall_retire,
  // Single-step trap flag of the processor flags word
  input  wire logic                         single_step_trap_flag,
  output logic                              step_trap_req,
  output logic                              trap_flag_clear,
  // Breakpoint matches and performance events
  input  wire logic [NUM_REPORT_PINS-1:0]   bp_match,
  input  wire logic [NUM_REPORT_PINS-1:0]   perf_event,
  output logic [NUM_REPORT_PINS-1:0]        breakpoint_report_pin_n,
  // Model-specific register port
  input  wire trace_pkg::msr_req_t          msr,
  output logic                              msr_done,
  output logic                              msr_fault,
  output logic [31:0]                       msr_rdata,
  // Branch trace message on the system bus
  output logic                              msg_valid,
  output trace_pkg::trace_msg_t             msg,
  input  wire logic                         msg_ready
);

  import trace_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic {
    MSG_IDLE,
    MSG_SEND
  } msg_state_t;

  logic                       record_enable_flag;
  logic                       branch_step_flag;
  logic [NUM_REPORT_PINS-1:0] pin_report_select;
  logic                       bus_message_enable;
  logic [31:0]                recent_transfer_source;
  logic [31:0]                recent_transfer_target;
  logic [31:0]                saved_transfer_source;
  logic [31:0]                saved_transfer_target;
  msg_state_t                 msg_state;
  trace_msg_t                 msg_hold;

  logic                       next_record_enable_flag;
  logic                       next_branch_step_flag;
  logic [NUM_REPORT_PINS-1:0] next_pin_report_select;
  logic                       next_bus_message_enable;
  logic [31:0]                next_recent_transfer_source;
  logic [31:0]                next_recent_transfer_target;
  logic [31:0]                next_saved_transfer_source;
  logic [31:0]                next_saved_transfer_target;
  msg_state_t                 next_msg_state;
  trace_msg_t                 next_msg_hold;
  logic                       next_msr_done;
  logic                       next_msr_fault;
  logic [31:0]                next_msr_rdata;
  logic                       next_step_trap_req;
  logic                       next_trap_flag_clear;

  logic                       xfer_take;
  logic                       xfer_normal;
  logic                       xfer_debug;
  logic                       msg_busy;
  logic [31:0]                control_word;
  logic [NUM_REPORT_PINS-1:0] pin_fire;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic index_known(input logic [9:0] idx);
    return (idx == IDX_DEBUG_CONTROL) || (idx == IDX_RECENT_SOURCE) ||
           (idx == IDX_RECENT_TARGET) || (idx == IDX_SAVED_SOURCE) ||
           (idx == IDX_SAVED_TARGET);
  endfunction

  // ****************************************************************
  // Transfer intake and back-pressure
  // ****************************************************************
  // A message still waiting for the bus blocks the next transfer, so
  // none is dropped; this is the throughput cost of bus tracing.
  assign msg_busy     = (msg_state == MSG_SEND);
  assign stall_retire = xfer.valid && bus_message_enable && msg_busy;
  assign xfer_take    = xfer.valid && !stall_retire;
  assign xfer_debug   = xfer_take && (xfer.kind == XFER_DEBUG);
  assign xfer_normal  = xfer_take && (xfer.kind != XFER_DEBUG);      // [RULE14]

  always_comb begin
    control_word = 32'h0000_0000;
    control_word[BIT_RECORD_ENABLE] = record_enable_flag;
    control_word[BIT_BRANCH_STEP]   = branch_step_flag;
    control_word[BIT_PIN_SELECT_LO +: NUM_REPORT_PINS] = pin_report_select;
    control_word[BIT_BUS_MESSAGE]   = bus_message_enable;
  end

  // ****************************************************************
  // Control flags and register port
  // ****************************************************************
  always_comb begin
    next_record_enable_flag = record_enable_flag;
    next_branch_step_flag   = branch_step_flag;
    next_pin_report_select  = pin_report_select;
    next_bus_message_enable = bus_message_enable;
    next_msr_done           = msr.rd || msr.wr;
    next_msr_fault          = 1'b0;
    next_msr_rdata          = 32'h0000_0000;
    if (msr.wr) begin
      if (msr.index == IDX_DEBUG_CONTROL && (msr.priv0 || msr.real_mode)) begin // [RULE15]
        next_record_enable_flag = msr.wdata[BIT_RECORD_ENABLE];
        next_branch_step_flag   = msr.wdata[BIT_BRANCH_STEP];
        next_pin_report_select  = msr.wdata[BIT_PIN_SELECT_LO +: NUM_REPORT_PINS];
        next_bus_message_enable = msr.wdata[BIT_BUS_MESSAGE];
      end else begin
        next_msr_fault = 1'b1;
      end
    end else if (msr.rd) begin
      next_msr_fault = !index_known(msr.index);
      unique case (msr.index)
        IDX_DEBUG_CONTROL: next_msr_rdata = control_word;
        IDX_RECENT_SOURCE: next_msr_rdata = recent_transfer_source;   // [RULE16]
        IDX_RECENT_TARGET: next_msr_rdata = recent_transfer_target;   // [RULE16]
        IDX_SAVED_SOURCE:  next_msr_rdata = saved_transfer_source;    // [RULE16]
        IDX_SAVED_TARGET:  next_msr_rdata = saved_transfer_target;    // [RULE16]
        default:           next_msr_rdata = 32'h0000_0000;
      endcase
    end
    // The handler must see both flags cleared, so the exception beats
    // a write landing in the same cycle
    if (xfer_debug) begin
      next_record_enable_flag = 1'b0;                                  // [RULE2]
      next_branch_step_flag   = 1'b0;                                  // [RULE5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      record_enable_flag <= DEBUG_CONTROL_RESET[BIT_RECORD_ENABLE];    // [RULE19]
      branch_step_flag   <= DEBUG_CONTROL_RESET[BIT_BRANCH_STEP];      // [RULE19]
      pin_report_select  <=
        DEBUG_CONTROL_RESET[BIT_PIN_SELECT_LO +: NUM_REPORT_PINS];     // [RULE19]
      bus_message_enable <= DEBUG_CONTROL_RESET[BIT_BUS_MESSAGE];      // [RULE19]
      msr_done           <= 1'b0;
      msr_fault          <= 1'b0;
      msr_rdata          <= 32'h0000_0000;
    end else begin
      record_enable_flag <= next_record_enable_flag;
      branch_step_flag   <= next_branch_step_flag;
      pin_report_select  <= next_pin_report_select;
      bus_message_enable <= next_bus_message_enable;
      msr_done           <= next_msr_done;
      msr_fault          <= next_msr_fault;
      msr_rdata          <= next_msr_rdata;
    end
  end

  // ****************************************************************
  // Last transfer capture
  // ****************************************************************
  always_comb begin
    next_recent_transfer_source = recent_transfer_source;
    next_recent_transfer_target = recent_transfer_target;
    next_saved_transfer_source  = saved_transfer_source;
    next_saved_transfer_target  = saved_transfer_target;
    // Capture pauses while bus messages run; the values then carry no
    // meaning for software
    if (xfer_normal && record_enable_flag && !bus_message_enable) begin // [RULE1] [RULE9]
      if (xfer.kind != XFER_BRANCH) begin
        next_saved_transfer_source = recent_transfer_source;            // [RULE13]
        next_saved_transfer_target = recent_transfer_target;            // [RULE13]
      end
      // Branch: branch address and target; otherwise the interrupted
      // instruction and the handler entry
      next_recent_transfer_source = xfer.from_ip;                       // [RULE11] [RULE12]
      next_recent_transfer_target = xfer.to_ip;                         // [RULE11] [RULE12]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      recent_transfer_source <= IP_RESET;
      recent_transfer_target <= IP_RESET;
      saved_transfer_source  <= IP_RESET;
      saved_transfer_target  <= IP_RESET;
    end else begin
      recent_transfer_source <= next_recent_transfer_source;
      recent_transfer_target <= next_recent_transfer_target;
      saved_transfer_source  <= next_saved_transfer_source;
      saved_transfer_target  <= next_saved_transfer_target;
    end
  end

  // ****************************************************************
  // Control-flow stepping
  // ****************************************************************
  // With branch step clear the core does its own per-instruction stepping
  // from the trap flag; this block only asks for the trap on transfers.
  always_comb begin
    next_step_trap_req   = xfer_normal && branch_step_flag &&
                           single_step_trap_flag;                      // [RULE3] [RULE4]
    next_trap_flag_clear = xfer_debug;                                 // [RULE5]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_trap_req   <= 1'b0;
      trap_flag_clear <= 1'b0;
    end else begin
      step_trap_req   <= next_step_trap_req;
      trap_flag_clear <= next_trap_flag_clear;
    end
  end

  // ****************************************************************
  // Bus trace messages
  // ****************************************************************
  always_comb begin
    next_msg_state = msg_state;
    next_msg_hold  = msg_hold;
    unique case (msg_state)
      MSG_IDLE: begin
        if (xfer_take && bus_message_enable) begin                     // [RULE8]
          next_msg_hold.from_ip = xfer.faulted ? xfer.from_ip
                                               : xfer.next_ip;         // [RULE10]
          next_msg_hold.to_ip   = xfer.to_ip;                          // [RULE8]
          next_msg_state        = MSG_SEND;
        end
      end
      MSG_SEND: begin
        if (msg_ready) begin
          next_msg_state = MSG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      msg_state <= MSG_IDLE;
      msg_hold  <= '0;
    end else begin
      msg_state <= next_msg_state;
      msg_hold  <= next_msg_hold;
    end
  end

  assign msg_valid = msg_busy;
  assign msg       = msg_hold;

  // ****************************************************************
  // Breakpoint report pins
  // ****************************************************************
  // Performance reporting only drives the pin; nothing here feeds back
  // into retirement, so execution is untouched.
  for (genvar i = 0; i < NUM_REPORT_PINS; i++) begin : g_pin
    assign pin_fire[i] = pin_report_select[i] ? bp_match[i]           // [RULE6]
                                              : perf_event[i];        // [RULE7]

    report_pin_pulse u_pulse (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .fire    (pin_fire[i]),
      .pin_n   (breakpoint_report_pin_n[i])
    );
  end

endmodule : branch_trace_recorder

`default_nettype wire

// ### tb/trace_chk.sv
// Checker for the branch trace recorder, bound to its top module.
// Assumes a single clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module trace_chk
  import trace_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // Transfers and stepping
  input  wire trace_pkg::xfer_evt_t       xfer,
  input  wire logic                       stall_retire,
  input  wire logic                       single_step_trap_flag,
  input  wire logic                       step_trap_req,
  input  wire logic                       trap_flag_clear,
  // Pins
  input  wire logic [NUM_REPORT_PINS-1:0] bp_match,
  input  wire logic [NUM_REPORT_PINS-1:0] perf_event,
  input  wire logic [NUM_REPORT_PINS-1:0] breakpoint_report_pin_n,
  // Register port
  input  wire trace_pkg::msr_req_t        msr,
  input  wire logic                       msr_done,
  input  wire logic                       msr_fault,
  input  wire logic [31:0]                msr_rdata,
  // Trace messages
  input  wire logic                       msg_valid,
  input  wire trace_pkg::trace_msg_t      msg,
  input  wire logic                       msg_ready
);
  wire logic taken;
  assign taken = xfer.valid && !stall_retire;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ************
  // Assertions
  // ************
  AST_MSR_DONE: assert property ((msr.rd || msr.wr) |=> msr_done)
    else $error("register access not answered");
  AST_RDATA_IDLE: assert property (!msr_done |-> msr_rdata == 32'h0)
    else $error("read data outside answer");
  AST_WR_REFUSED: assert property (msr.wr && msr.index == IDX_DEBUG_CONTROL
      && !msr.priv0 && !msr.real_mode |=> msr_fault)
    else $error("unprivileged control write accepted");
  AST_RO_REFUSED: assert property (msr.wr && msr.index != IDX_DEBUG_CONTROL |=> msr_fault)
    else $error("pointer register write accepted");
  AST_STEP_CAUSE: assert property (step_trap_req |->
      $past(taken && xfer.kind != XFER_DEBUG && single_step_trap_flag))
    else $error("step trap without stepped transfer");
  AST_DEBUG_CLEAR: assert property (taken && xfer.kind == XFER_DEBUG |=> trap_flag_clear)
    else $error("debug transfer left trap flag");
  AST_PIN_PULSE: assert property ($fell(breakpoint_report_pin_n[0]) |->
      $past(bp_match[0] || perf_event[0]) ##1 !breakpoint_report_pin_n[0])
    else $error("report pin pulse wrong");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg))
    else $error("trace message dropped or changed");
  AST_STALL_CAUSE: assert property (stall_retire |-> msg_valid && xfer.valid)
    else $error("stall without waiting message");

  COV_STEP: cover property (step_trap_req);
  COV_MSG: cover property (msg_valid && msg_ready);
  COV_PIN: cover property ($fell(breakpoint_report_pin_n[0]));
endmodule // trace_chk

bind branch_trace_recorder trace_chk chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .xfer(xfer), .stall_retire(stall_retire),
  .single_step_trap_flag(single_step_trap_flag), .step_trap_req(step_trap_req),
  .trap_flag_clear(trap_flag_clear), .bp_match(bp_match), .perf_event(perf_event),
  .breakpoint_report_pin_n(breakpoint_report_pin_n), .msr(msr), .msr_done(msr_done),
  .msr_fault(msr_fault), .msr_rdata(msr_rdata), .msg_valid(msg_valid), .msg(msg),
  .msg_ready(msg_ready)
);

`default_nettype wire

// ### tb/core_model.sv
// Core retirement model: presents one transfer at a time, holds it while
// stalled, answers a step trap with a debug transfer.
// Assumes go is pulsed only while busy is low.
`timescale 1ns/10ps
`default_nettype none

module core_model
  import trace_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Bench commands
  input  wire logic                 go,
  input  wire logic                 set_tf,
  input  wire trace_pkg::xfer_evt_t evt,
  output logic                      busy,
  // Recorder side
  output trace_pkg::xfer_evt_t      xfer,
  input  wire logic                 stall_retire,
  output logic                      tf,
  input  wire logic                 step_trap_req,
  input  wire logic                 trap_flag_clear
);
  localparam logic [31:0] DEBUG_HANDLER = 32'h0000_0c00;
  logic dbg_pend;

  assign busy = xfer.valid | dbg_pend | step_trap_req;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xfer     <= '0;
      tf       <= 1'b0;
      dbg_pend <= 1'b0;
    end else begin
      // Once taken, valid and the top kind bit are cleared and the rest inverted, so a stale copy never looks valid
      if (xfer.valid && !stall_retire) begin
        xfer <= {1'b0, ~xfer[97:0]};
      end
      if (go) begin
        xfer <= evt;
      end else if (dbg_pend && !xfer.valid) begin
        xfer <= '{1'b1, XFER_DEBUG, 1'b0, evt.to_ip, evt.to_ip, DEBUG_HANDLER};
      end
      dbg_pend <= step_trap_req | (dbg_pend & xfer.valid);
      if (trap_flag_clear) begin
        tf <= 1'b0;
      end else if (set_tf) begin
        tf <= 1'b1;
      end
    end
  end
endmodule // core_model

`default_nettype wire

// ### tb/branch_trace_recorder_bench.sv
// Self-checking bench for the branch trace recorder.
// Assumes the core model drives transfers and the bench plays software.
`timescale 1ns/10ps
`default_nettype none

module branch_trace_recorder_bench;
  import trace_pkg::*;
  logic clk_sys, sys_rst, go, set_tf, busy, tf, stall_retire, step_trap_req;
  logic trap_flag_clear, msr_done, msr_fault, msg_valid, msg_ready, flt;
  logic step_seen, clr_seen;
  xfer_evt_t evt, xfer;
  msr_req_t msr;
  trace_msg_t msg;
  logic [3:0] bp_match, perf_event, pin_n, exp;
  logic [31:0] msr_rdata, rdv;
  int fail_count, comparisons, cycles;

  core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .set_tf(set_tf),
    .evt(evt), .busy(busy), .xfer(xfer), .stall_retire(stall_retire), .tf(tf),
    .step_trap_req(step_trap_req), .trap_flag_clear(trap_flag_clear));
  branch_trace_recorder dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .xfer(xfer),
    .stall_retire(stall_retire), .single_step_trap_flag(tf), .step_trap_req(step_trap_req),
    .trap_flag_clear(trap_flag_clear), .bp_match(bp_match), .perf_event(perf_event),
    .breakpoint_report_pin_n(pin_n), .msr(msr), .msr_done(msr_done), .msr_fault(msr_fault),
    .msr_rdata(msr_rdata), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Sticky event flags and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (step_trap_req === 1'b1) step_seen <= 1'b1;
    if (trap_flag_clear === 1'b1) clr_seen <= 1'b1;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  // ************
  // Helpers
  // ************
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("ERROR %0t: got %h, expected %h", $time, got, want);
    end
  endtask
  task automatic chk1(input logic got, input logic want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, want);
    end
  endtask
  task automatic reg_op(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                        input logic p, input logic r);
    @(posedge clk_sys);
    msr <= '{rd: !w, wr: w, index: idx, wdata: wd, priv0: p, real_mode: r};
    @(posedge clk_sys);
    msr <= '0;
    #1;
    rdv = msr_rdata;
    flt = msr_fault;
    chk1(msr_done, 1'b1);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] want);
    reg_op(1'b0, idx, 32'h0, 1'b1, 1'b0);
    chk32(rdv, want);
  endtask
  task automatic wr_chk(input logic [31:0] wd, input logic p, r, want_fault);
    reg_op(1'b1, IDX_DEBUG_CONTROL, wd, p, r);
    chk1(flt, want_fault);
  endtask
  task automatic pair(input logic saved, input logic [31:0] s, t);
    rd_chk(saved ? IDX_SAVED_SOURCE : IDX_RECENT_SOURCE, s);
    rd_chk(saved ? IDX_SAVED_TARGET : IDX_RECENT_TARGET, t);
  endtask
  task automatic send(input xfer_kind_t k, input logic f, input logic [31:0] a, b, c);
    @(posedge clk_sys);
    go  <= 1'b1;
    evt <= '{1'b1, k, f, a, b, c};
    @(posedge clk_sys);
    go  <= 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk1(busy, 1'b0);
    repeat (3) @(posedge clk_sys);
  endtask

  // ************
  // Scenarios
  // ************
  task automatic t_reset();
    rd_chk(IDX_DEBUG_CONTROL, DEBUG_CONTROL_RESET);
    pair(1'b0, IP_RESET, IP_RESET);
    pair(1'b1, IP_RESET, IP_RESET);
    reg_op(1'b0, 10'h1da, 32'h0, 1'b1, 1'b0);
    chk1(flt, 1'b1);
    chk32(rdv, 32'h0);
  endtask
  task automatic t_access();
    wr_chk(32'hffff_ffff, 1'b0, 1'b0, 1'b1);
    rd_chk(IDX_DEBUG_CONTROL, 32'h0);
    wr_chk(32'hffff_ff81, 1'b0, 1'b1, 1'b0);
    rd_chk(IDX_DEBUG_CONTROL, 32'h1);
    reg_op(1'b1, IDX_RECENT_SOURCE, 32'h5, 1'b1, 1'b0);
    chk1(flt, 1'b1);
  endtask
  task automatic t_record();
    send(XFER_BRANCH, 1'b0, 32'h10, 32'h14, 32'h20);
    idle();
    pair(1'b0, 32'h10, 32'h20);
    send(XFER_INTERRUPT, 1'b0, 32'h30, 32'h34, 32'h40);
    idle();
    pair(1'b1, 32'h10, 32'h20);
    pair(1'b0, 32'h30, 32'h40);
    send(XFER_EXCEPTION, 1'b0, 32'h50, 32'h54, 32'h60);
    idle();
    pair(1'b1, 32'h30, 32'h40);
    pair(1'b0, 32'h50, 32'h60);
  endtask
  task automatic t_step();
    @(posedge clk_sys);
    set_tf    <= 1'b1;
    step_seen <= 1'b0;
    clr_seen  <= 1'b0;
    @(posedge clk_sys);
    set_tf <= 1'b0;
    send(XFER_BRANCH, 1'b0, 32'h70, 32'h74, 32'h80);
    idle();
    chk1(step_seen, 1'b0);
    wr_chk(32'h3, 1'b1, 1'b0, 1'b0);
    send(XFER_BRANCH, 1'b0, 32'h90, 32'h94, 32'ha0);
    idle();
    idle();
    chk1(step_seen, 1'b1);
    chk1(clr_seen, 1'b1);
    chk1(tf, 1'b0);
    rd_chk(IDX_DEBUG_CONTROL, 32'h0);
    pair(1'b0, 32'h90, 32'ha0);
    pair(1'b1, 32'h30, 32'h40);
    wr_chk(32'h3, 1'b1, 1'b0, 1'b0);
    rd_chk(IDX_DEBUG_CONTROL, 32'h3);
  endtask
  task automatic t_pins();
    wr_chk(32'h4, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      exp = (i == 0) ? 4'he : 4'hd;
      @(posedge clk_sys);
      bp_match   <= (i == 0) ? 4'h3 : 4'h0;
      perf_event <= (i == 0) ? 4'h0 : 4'h3;
      @(posedge clk_sys);
      bp_match   <= 4'h0;
      perf_event <= 4'h0;
      for (int j = 0; j <= PIN_PULSE_CYCLES; j++) begin
        #1;
        chk32({28'h0, pin_n}, (j < PIN_PULSE_CYCLES) ? {28'h0, exp} : 32'hf);
        @(posedge clk_sys);
      end
    end
  endtask
  // Pointer registers are not read here: their contents are undefined
  task automatic t_msg();
    wr_chk(32'h40, 1'b1, 1'b0, 1'b0);
    send(XFER_BRANCH, 1'b0, 32'h100, 32'h104, 32'h200);
    idle();
    chk1(msg_valid, 1'b1);
    chk32(msg.from_ip, 32'h104);
    chk32(msg.to_ip, 32'h200);
    send(XFER_EXCEPTION, 1'b1, 32'h300, 32'h304, 32'h400);
    #1;
    chk1(stall_retire, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk32(msg.from_ip, 32'h104);
    msg_ready <= 1'b1;
    @(posedge clk_sys);
    msg_ready <= 1'b0;
    idle();
    chk32(msg.from_ip, 32'h300);
    chk32(msg.to_ip, 32'h400);
    @(posedge clk_sys);
    msg_ready <= 1'b1;
    @(posedge clk_sys);
    msg_ready <= 1'b0;
    #1;
    chk1(msg_valid, 1'b0);
  endtask

  initial begin
    sys_rst = 1'b1;
    {go, set_tf, msg_ready, step_seen, clr_seen} = 5'h0;
    evt = '0;
    msr = '0;
    bp_match = 4'h0;
    perf_event = 4'h0;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_access();
    t_record();
    t_step();
    t_pins();
    t_msg();
    summarize();
  end
endmodule // branch_trace_recorder_bench

`default_nettype wire
